// >>> src/adc_excitation_temp_monitor_ctrl.v
// Behaviour
// - First conversion starts 28.5 (normal) or 105 (turbo) clocks after start command.
// - Conversions timed in master clock periods, 1.024 MHz normal, 2.048 MHz turbo.
// - Two matched excitation sources, three-bit magnitude selects 10 to 1500 uA.
// - Each source routed by own field to any input or reference; 000 unrouted.
// - Single-shot keeps sources on between conversions; sleep command powers them down.
// - Bias on when magnitude nonzero; current drawn only when routing nonzero.
// - Burn-out enable sources 10 uA into positive input, sinks from negative.
// - Monitor selection bypasses amplifier with gain 1 unless the temperature bit is set.
// - Selector 1101 converts quarter supply using internal reference.
// - Selector 1100 converts quarter external reference using internal reference.
// - Temperature bit set selects sensor mode, ignoring first config, internal reference.
// - Temperature conversions start and read back like analog conversions.
// - Temperature result is 14 bits left-justified in 24-bit word.
// - One temperature step is 0.03125 C; 25 C is 0320.
// - Negative temperatures are 14-bit two's complement.
// - Result bytes sent least significant byte first.
`include "adc_ctrl_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module adc_excitation_temp_monitor_ctrl #(
    parameter [15:0] CONV_CYCLES = 16'd1036
) (
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    input  wire [4:0]  i_address,
    input  wire        i_read,
    input  wire        i_write,
    input  wire [31:0] i_writedata,
    input  wire [3:0]  i_byteenable,
    input  wire [23:0] i_adc_sample,
    input  wire [13:0] i_temp_sample,
    output reg  [31:0] o_readdata,
    output reg         o_waitrequest,
    output reg         o_exc_bias_on,
    output reg  [2:0]  o_excitation_level_sel,
    output reg  [2:0]  o_first_source_route,
    output reg  [2:0]  o_second_source_route,
    output reg         o_burnout_source_enable,
    output reg  [3:0]  o_input_selector,
    output reg         o_amp_bypass_gain1,
    output reg         o_use_internal_ref,
    output reg         o_temperature_mode_bit,
    output reg         o_converting,
    output reg         o_data_ready
);
    // ****************************************
    // Master clock enable
    // ****************************************
    // Phase accumulator gives an average-exact master clock tick from 40 MHz
    function [16:0] acc_step;
        input turbo;
        begin
            acc_step = turbo ? 17'd2048 : 17'd1024;
        end
    endfunction
    reg  [16:0] phase;
    reg         mclk_tick;
    reg  [7:0]  cfg;
    reg  [11:0] exc;
    wire [16:0] next_phase = phase + acc_step(cfg[`CFG_TURBO]);
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            phase     <= 17'h0;
            mclk_tick <= 1'b0;
        end else if (next_phase >= 17'd40000) begin
            phase     <= next_phase - 17'd40000;
            mclk_tick <= 1'b1;
        end else begin
            phase     <= next_phase;
            mclk_tick <= 1'b0;
        end
    end
    // Half-period ticks let the 28.5-period latency be counted exactly
    reg         half_tick;
    reg  [16:0] half_phase;
    wire [16:0] step = acc_step(cfg[`CFG_TURBO]);
    // Step never exceeds 2048, so dropping its top bit loses nothing
    wire [16:0] next_half = half_phase + {step[15:0], 1'b0};
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            half_phase <= 17'h0;
            half_tick  <= 1'b0;
        end else if (next_half >= 17'd40000) begin
            half_phase <= next_half - 17'd40000;
            half_tick  <= 1'b1;
        end else begin
            half_phase <= next_half;
            half_tick  <= 1'b0;
        end
    end
    // ****************************************
    // Avalon slave
    // ****************************************
    reg        cmd_start;
    reg        cmd_sleep;
    reg        ack;
    reg [23:0] result;
    reg [13:0] temp_code;
    reg        act_temp;
    wire       req = (i_read | i_write) & ~ack;
    // Read data is chosen in one place so every readable register shares the decode
    function [31:0] read_mux;
        input [4:0]  addr;
        input [7:0]  c;
        input [11:0] e;
        input [2:0]  st;
        input [23:0] res;
        input [13:0] tc;
        begin
            case (addr)
                `REG_CFG:    read_mux = {24'h0, c};
                `REG_EXC:    read_mux = {20'h0, e};
                `REG_STATUS: read_mux = {29'h0, st};
                `REG_RESULT: read_mux = {8'h0, res};
                `REG_TEMP:   read_mux = {18'h0, tc};
                default:     read_mux = 32'h0;
            endcase
        end
    endfunction
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            cfg           <= `CFG_RESET;
            exc           <= `EXC_RESET;
            cmd_start     <= 1'b0;
            cmd_sleep     <= 1'b0;
            ack           <= 1'b0;
            o_waitrequest <= 1'b1;
            o_readdata    <= 32'h0;
        end else begin
            cmd_start     <= 1'b0;
            cmd_sleep     <= 1'b0;
            ack           <= req;
            o_waitrequest <= ~req;
            if (req && i_write) begin
                case (i_address)
                    `REG_CFG: if (i_byteenable[0]) cfg <= i_writedata[7:0];
                    `REG_EXC: begin
                        if (i_byteenable[0]) exc[7:0]  <= i_writedata[7:0];
                        if (i_byteenable[1]) exc[11:8] <= i_writedata[11:8];
                    end
                    `REG_CMD: if (i_byteenable[0]) begin
                        cmd_start <= i_writedata[`CMD_START];
                        cmd_sleep <= i_writedata[`CMD_SLEEP];
                    end
                    default: ;
                endcase
            end
            // Result low byte sits at the lowest byte lane, so a byte-wise reader gets it first
            if (req && i_read) begin
                o_readdata <= read_mux(i_address, cfg, exc, {act_temp, o_data_ready, o_converting},
                                       result, temp_code);
            end
        end
    end
    // ****************************************
    // Conversion sequencer
    // ****************************************
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_LAT   = 2'd1;
    localparam [1:0] ST_CONV  = 2'd2;
    localparam [1:0] ST_SLEEP = 2'd3;
    reg [1:0]  state;
    reg [7:0]  lat_cnt;
    reg [15:0] conv_cnt;
    reg        sleep_pend;
    reg        act_turbo;
    reg [3:0]  act_sel;
    reg        act_burn;
    reg [2:0]  act_level;
    reg [2:0]  act_r1;
    reg [2:0]  act_r2;
    // Both monitor codes force the internal reference, and gain 1 unless the temperature bit is set
    function is_monitor;
        input [3:0] s;
        begin
            is_monitor = (s == `SEL_SUPPLY) || (s == `SEL_REFMON);
        end
    endfunction
    wire       act_monitor = is_monitor(act_sel);
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            state        <= ST_SLEEP;
            lat_cnt      <= 8'h0;
            conv_cnt     <= 16'h0;
            sleep_pend   <= 1'b0;
            act_turbo    <= 1'b0;
            act_sel      <= 4'h0;
            act_burn     <= 1'b0;
            act_temp     <= 1'b0;
            act_level    <= 3'h0;
            act_r1       <= `ROUTE_NONE;
            act_r2       <= `ROUTE_NONE;
            result       <= 24'h0;
            temp_code    <= 14'h0;
            o_data_ready <= 1'b0;
        end else begin
            if (cmd_sleep) sleep_pend <= 1'b1;
            case (state)
                ST_IDLE, ST_SLEEP: begin
                    if (cmd_start) begin
                        // Selector, burn-out, temperature and excitation settings snapshot at start; the tick rates still follow the live cfg turbo bit
                        act_turbo    <= cfg[`CFG_TURBO];
                        act_sel      <= cfg[3:0];
                        act_burn     <= cfg[`CFG_BURNOUT];
                        act_temp     <= cfg[`CFG_TEMP];
                        act_level    <= exc[2:0];
                        act_r1       <= exc[6:4];
                        act_r2       <= exc[10:8];
                        lat_cnt      <= cfg[`CFG_TURBO] ? `LAT_TURBO_HALF : `LAT_NORMAL_HALF;
                        sleep_pend   <= 1'b0;
                        o_data_ready <= 1'b0;
                        state        <= ST_LAT;
                    end else if (sleep_pend) begin
                        sleep_pend <= 1'b0;
                        state      <= ST_SLEEP;
                    end
                end
                ST_LAT: if (half_tick) begin
                    if (lat_cnt == 8'd1) begin
                        conv_cnt <= CONV_CYCLES;
                        state    <= ST_CONV;
                    end else begin
                        lat_cnt <= lat_cnt - 8'd1;
                    end
                end
                ST_CONV: if (mclk_tick) begin
                    if (conv_cnt == 16'd1) begin
                        // Temperature code left-justified, low bits zero
                        result       <= act_temp ? {i_temp_sample, 10'h0} : i_adc_sample;
                        temp_code    <= i_temp_sample;
                        o_data_ready <= 1'b1;
                        if (sleep_pend || cmd_sleep) begin
                            sleep_pend <= 1'b0;
                            state      <= ST_SLEEP;
                        end else if (cfg[`CFG_SINGLE]) begin
                            state <= ST_IDLE;
                        end else begin
                            act_turbo <= cfg[`CFG_TURBO];
                            act_sel   <= cfg[3:0];
                            act_burn  <= cfg[`CFG_BURNOUT];
                            act_temp  <= cfg[`CFG_TEMP];
                            act_level <= exc[2:0];
                            act_r1    <= exc[6:4];
                            act_r2    <= exc[10:8];
                            conv_cnt  <= CONV_CYCLES;
                        end
                    end else begin
                        conv_cnt <= conv_cnt - 16'd1;
                    end
                end
                default: state <= ST_SLEEP;
            endcase
        end
    end
    // ****************************************
    // Analog control outputs
    // ****************************************
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_exc_bias_on           <= 1'b0;
            o_excitation_level_sel  <= 3'h0;
            o_first_source_route    <= `ROUTE_NONE;
            o_second_source_route   <= `ROUTE_NONE;
            o_burnout_source_enable <= 1'b0;
            o_input_selector        <= 4'h0;
            o_amp_bypass_gain1      <= 1'b0;
            o_use_internal_ref      <= 1'b0;
            o_temperature_mode_bit  <= 1'b0;
            o_converting            <= 1'b0;
        end else begin
            // Sources stay biased while idle between single-shots, off only in sleep or at zero level
            o_exc_bias_on           <= (state != ST_SLEEP) && (act_level != 3'h0);
            o_excitation_level_sel  <= act_level;
            o_first_source_route    <= (state != ST_SLEEP) ? act_r1 : `ROUTE_NONE;
            o_second_source_route   <= (state != ST_SLEEP) ? act_r2 : `ROUTE_NONE;
            o_burnout_source_enable <= act_burn && (state == ST_CONV || state == ST_LAT);
            o_input_selector        <= act_sel;
            o_amp_bypass_gain1      <= act_monitor && !act_temp;
            o_use_internal_ref      <= act_monitor || act_temp;
            o_temperature_mode_bit  <= act_temp;
            o_converting            <= (state == ST_LAT) || (state == ST_CONV);
        end
    end
endmodule
`default_nettype wire

// >>> src/adc_ctrl_regs.vh
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define REG_CFG      4'h0
`define REG_EXC      4'h4
`define REG_CMD      4'h8
`define REG_STATUS   4'hc
`define REG_RESULT   5'h10
`define REG_TEMP     5'h14
// ****************************************
// Field positions
// ****************************************
`define CFG_SEL_LSB    0
`define CFG_TURBO      4
`define CFG_TEMP       5
`define CFG_BURNOUT    6
`define CFG_SINGLE     7
`define EXC_LEVEL_LSB  0
`define EXC_R1_LSB     4
`define EXC_R2_LSB     8
`define CMD_START      0
`define CMD_SLEEP      1
// ****************************************
// Reset values and codes
// ****************************************
`define CFG_RESET      8'h00
`define EXC_RESET      12'h000
`define SEL_SUPPLY     4'hd
`define SEL_REFMON     4'hc
`define ROUTE_NONE     3'h0
// ****************************************
// Timing: start latency in half master-clock periods, clock rates in kHz
// ****************************************
`define LAT_NORMAL_HALF  8'd57
`define LAT_TURBO_HALF   8'd210
`define MCLK_NORMAL_KHZ  1024
`define MCLK_TURBO_KHZ   2048
`define REF_CLK_KHZ      40000
`endif

// >>> bench/adc_sample_source.sv
`timescale 1ns/100ps
`default_nettype none
module adc_sample_source (
    input  wire logic        i_ref_clk,
    input  wire logic [13:0] i_temp_value,
    output var  logic [23:0] o_adc_sample,
    output var  logic [13:0] o_temp_sample
);
    // Settled sensor: values move only when the bench changes them
    always @(posedge i_ref_clk) begin
        o_adc_sample  <= 24'h5a3c1e;
        o_temp_sample <= i_temp_value;
    end
endmodule
`default_nettype wire

// >>> bench/adc_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_checker #(parameter [15:0] CONV_CYCLES = 16'd1036) (
    input wire logic       i_ref_clk,
    input wire logic       i_rst_b,
    input wire logic       i_read,
    input wire logic       i_write,
    input wire logic       o_waitrequest,
    input wire logic       o_exc_bias_on,
    input wire logic [2:0] o_excitation_level_sel,
    input wire logic [3:0] o_input_selector,
    input wire logic       o_amp_bypass_gain1,
    input wire logic       o_use_internal_ref,
    input wire logic       o_temperature_mode_bit,
    input wire logic       o_converting,
    input wire logic       o_data_ready
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // 28.5 + N master periods, less one tick of phase slack on each counter
    localparam int MIN_RUN = 39 * CONV_CYCLES + 1050;
    logic [15:0] idle_cnt;
    wire mon = o_converting && !o_temperature_mode_bit && o_input_selector[3:1] == 3'h6;
    always @(posedge i_ref_clk) begin
        idle_cnt <= (!i_rst_b || o_data_ready) ? 16'h0000 : idle_cnt + 16'h0001;
    end
    sequence s_ack;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    property p_answer; $rose(i_read || i_write) |-> ##[1:2] s_ack; endproperty
    property p_ack_req; !o_waitrequest |-> $past(i_read || i_write); endproperty
    property p_bias; o_exc_bias_on |-> o_excitation_level_sel != 3'h0; endproperty
    property p_gain1; mon |-> o_amp_bypass_gain1; endproperty
    property p_monref; mon |-> o_use_internal_ref; endproperty
    property p_tempref; o_converting && o_temperature_mode_bit |-> o_use_internal_ref; endproperty
    property p_temp_amp; o_converting && o_temperature_mode_bit |-> !o_amp_bypass_gain1; endproperty
    property p_run_time; $rose(o_data_ready) |-> idle_cnt >= MIN_RUN; endproperty
    a_answer: assert property (p_answer) else $error("no single-cycle answer");
    a_ack_req: assert property (p_ack_req) else $error("answer without request");
    a_bias: assert property (p_bias) else $error("bias on at zero level");
    a_gain1: assert property (p_gain1) else $error("monitor without gain 1");
    a_monref: assert property (p_monref) else $error("monitor without internal ref");
    a_tempref: assert property (p_tempref) else $error("temp without internal ref");
    a_temp_amp: assert property (p_temp_amp) else $error("temp mode bypassed amp");
    a_run_time: assert property (p_run_time) else $error("result too early");
endmodule
bind adc_excitation_temp_monitor_ctrl adc_ctrl_checker #(.CONV_CYCLES(CONV_CYCLES)) adc_ctrl_checker_inst (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_read(i_read), .i_write(i_write),
    .o_waitrequest(o_waitrequest), .o_exc_bias_on(o_exc_bias_on),
    .o_excitation_level_sel(o_excitation_level_sel), .o_input_selector(o_input_selector),
    .o_amp_bypass_gain1(o_amp_bypass_gain1), .o_use_internal_ref(o_use_internal_ref),
    .o_temperature_mode_bit(o_temperature_mode_bit), .o_converting(o_converting),
    .o_data_ready(o_data_ready));
`default_nettype wire

// >>> bench/test_adc_excitation_temp_monitor_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_regs.vh"
module test_adc_excitation_temp_monitor_ctrl;
    logic        i_ref_clk = 0, i_rst_b = 0, i_read = 0, i_write = 0;
    logic [4:0]  i_address = 5'h00;
    logic [31:0] i_writedata = 32'h0, rd;
    logic [13:0] temp_value = 14'h0000;
    logic [13:0] temps [5] = '{14'h0320, 14'h3ce0, 14'h3b00, 14'h1000, 14'h0001};
    wire  [23:0] adc_s;
    wire  [13:0] temp_s;
    wire  [31:0] o_readdata;
    wire  [2:0]  lvl, r1, r2;
    wire  [3:0]  sel;
    wire         wreq, bias, burn, byp, iref, tmode, conv, rdy;
    int          n_errors = 0, n_checks = 0, cyc, cycles = 0, t0 = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    adc_sample_source adc_sample_source_inst (.i_ref_clk(i_ref_clk), .i_temp_value(temp_value),
        .o_adc_sample(adc_s), .o_temp_sample(temp_s));
    adc_excitation_temp_monitor_ctrl #(.CONV_CYCLES(16'd8)) adc_excitation_temp_monitor_ctrl_inst (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hf), .i_adc_sample(adc_s),
        .i_temp_sample(temp_s), .o_readdata(o_readdata), .o_waitrequest(wreq), .o_exc_bias_on(bias),
        .o_excitation_level_sel(lvl), .o_first_source_route(r1), .o_second_source_route(r2),
        .o_burnout_source_enable(burn), .o_input_selector(sel), .o_amp_bypass_gain1(byp),
        .o_use_internal_ref(iref), .o_temperature_mode_bit(tmode), .o_converting(conv),
        .o_data_ready(rdy));
    task stop_test;
        $display("Checks: %0d, errors: %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        chk({31'h0, got >= lo && got <= hi}, 32'h1);
    endtask
    // Holds the request until the edge that samples waitrequest low, then lets one edge pass
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_address <= a;
        i_writedata <= d;
        i_read <= !wr;
        i_write <= wr;
        do @(posedge i_ref_clk); while (wreq !== 1'b0 && ++n < 20);
        chk({31'h0, n < 20}, 32'h1);
        rd = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    // Timing is taken from the start command itself, not from the end of the bus call
    task automatic go;
        t0 = cycles;
        bus(1'b1, `REG_CMD, 32'h1);
        repeat (20) @(posedge i_ref_clk);
    endtask
    task automatic wait_rdy;
        while (rdy !== 1'b1 && cycles - t0 < 9000) @(posedge i_ref_clk);
        cyc = cycles - t0;
    endtask
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            stop_test;
        end
    end
    initial begin
        repeat (4) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        @(posedge i_ref_clk);
        bus(1'b0, `REG_CFG, 32'h0);
        chk(rd, {24'h0, `CFG_RESET});
        bus(1'b0, `REG_EXC, 32'h0);
        chk(rd, {20'h0, `EXC_RESET});
        bus(1'b0, 5'h18, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `REG_EXC, 32'h6);
        repeat (8000) @(posedge i_ref_clk);
        bus(1'b1, `REG_EXC, 32'h336);
        bus(1'b1, `REG_CFG, 32'hcd);
        go;
        chk({22'h0, bias, lvl, r1, r2}, {22'h0, 1'b1, 3'h6, 3'h3, 3'h3});
        chk({25'h0, burn, sel, byp, iref}, {25'h0, 1'b1, 4'hd, 1'b1, 1'b1});
        bus(1'b1, `REG_CFG, 32'h8c);
        chk({28'h0, sel}, {28'h0, `SEL_SUPPLY});
        wait_rdy;
        chk_rng(cyc, 1360, 1440);
        bus(1'b0, `REG_RESULT, 32'h0);
        chk(rd, 32'h005a3c1e);
        go;
        chk({25'h0, burn, sel, byp, iref}, {25'h0, 1'b0, 4'hc, 1'b1, 1'b1});
        wait_rdy;
        bus(1'b1, `REG_CFG, 32'h92);
        go;
        wait_rdy;
        chk_rng(cyc, 2160, 2230);
        bus(1'b1, `REG_CFG, 32'ha0);
        foreach (temps[i]) begin
            temp_value <= temps[i];
            go;
            chk({30'h0, tmode, iref}, 32'h3);
            wait_rdy;
            bus(1'b0, `REG_RESULT, 32'h0);
            chk(rd, {8'h0, temps[i], 10'h000});
            bus(1'b0, `REG_TEMP, 32'h0);
            chk(rd, {18'h0, temps[i]});
        end
        chk({31'h0, bias}, 32'h1);
        bus(1'b0, `REG_STATUS, 32'h0);
        chk(rd, 32'h6);
        bus(1'b1, `REG_CFG, 32'h00);
        go;
        wait_rdy;
        repeat (5) @(posedge i_ref_clk);
        chk({30'h0, conv, rdy}, 32'h3);
        bus(1'b1, `REG_CMD, 32'h2);
        repeat (400) @(posedge i_ref_clk);
        chk({24'h0, conv, bias, r1, r2}, 32'h0);
        stop_test;
    end
endmodule
`default_nettype wire
